// file: hw/bsm_cfg.svh
// Offsets, field positions, reset values and widths of the bridge window block.
`ifndef BSM_CFG_SVH
`define BSM_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses on the 16-bit configuration port)
// ==========================================================================
`define BSM_ADDR_W 8
`define BSM_OFF_SEC_STATUS 8'h1e
`define BSM_OFF_MEM_BASE 8'h20
`define BSM_OFF_MEM_LIMIT 8'h22
`define BSM_OFF_PF_BASE 8'h24
`define BSM_OFF_PF_LIMIT 8'h26
`define BSM_OFF_PF_BASE_UP_LO 8'h28
`define BSM_OFF_PF_BASE_UP_HI 8'h2a
`define BSM_OFF_PF_LIMIT_UP_LO 8'h2c
`define BSM_OFF_PF_LIMIT_UP_HI 8'h2e
`define BSM_OFF_BRIDGE_CTRL 8'h3e
`define BSM_OFF_IRQ_STATUS 8'h80
`define BSM_OFF_IRQ_MASK 8'h82

// ==========================================================================
// Field positions
// ==========================================================================
`define BSM_BIT_RX_SYS_ERR 14
`define BSM_BIT_PARITY_ERR 15
`define BSM_BIT_PF_CAP 0
`define BSM_BIT_SERR_EN 1
`define BSM_FLD_ADDR_HI 15
`define BSM_FLD_ADDR_LO 4
`define BSM_IRQ_W 2
`define BSM_IRQ_SYS_ERR 0
`define BSM_IRQ_PARITY 1

// ==========================================================================
// Reset values
// ==========================================================================
`define BSM_MEM_BASE_RST 12'hfff
`define BSM_MEM_LIMIT_RST 12'h000
`define BSM_PF_BASE_RST 12'hfff
`define BSM_PF_LIMIT_RST 12'h000
`define BSM_PF_CAP_RST 1'b1
`define BSM_PF_BASE_UP_RST 32'h0000000f
`define BSM_PF_LIMIT_UP_RST 32'h00000000

// ==========================================================================
// Window geometry: 1 MB granules, low 20 bits implied
// ==========================================================================
`define BSM_GRAIN_W 20
`define BSM_GRAIN_ONES 20'hfffff
`define BSM_GRAIN_ZERO 20'h00000

`endif

// file: hw/bsm_pkg.sv
// Types shared by the bridge window block.
package bsm_pkg;

    // ======================================================================
    // Data types
    // ======================================================================
    typedef logic [15:0] bsm_word_t;
    typedef logic [11:0] bsm_field_t;
    typedef logic [63:0] bsm_addr_t;

    // Kind of memory transaction offered for a forwarding decision.
    typedef enum logic {
        BSM_TXN_NONPREF = 1'b0,
        BSM_TXN_PREF = 1'b1
    } bsm_txn_kind_t;

endpackage : bsm_pkg

// file: hw/bsm_win_if.sv
// Interface carrying one window and the address tested against it.
`timescale 1ns/100ps
`default_nettype none

interface bsm_win_if;
    bsm_pkg::bsm_addr_t lo;
    bsm_pkg::bsm_addr_t hi;
    bsm_pkg::bsm_addr_t addr;
    logic hit;

    modport owner (output lo, output hi, output addr, input hit);
    modport cmp (input lo, input hi, input addr, output hit);
endinterface : bsm_win_if

`default_nettype wire

// file: hw/bsm_win_cmp.sv
// Address window comparator shared by both memory windows.
`timescale 1ns/100ps
`default_nettype none

module bsm_win_cmp (
    // Window and address under test
    bsm_win_if.cmp win
);

    // ======================================================================
    // Comparison
    // ======================================================================
    // A base above the limit switches the window off rather than wrapping.
    wire win_open = (win.lo <= win.hi);
    wire not_below = (win.addr >= win.lo);
    wire not_above = (win.addr <= win.hi);

    assign win.hit = win_open && not_below && not_above;

endmodule : bsm_win_cmp

`default_nettype wire

// file: hw/bsm_bridge_window.sv
// Secondary status flags and memory forwarding windows of a bridge header.
`timescale 1ns/100ps
`default_nettype none
`include "bsm_cfg.svh"

// How it works
// - error message with enable sets bit 14
// - enable clear never sets bit 14
// - poisoned packet always sets bit 15
// - status bits 8 to 13 read zero
// - memory base field, reset all ones
// - memory limit field, low bits ones
// - memory window decides non-prefetchable forwarding
// - lockable capability bit selects 32/64 bit
// - prefetch base field, reset all ones
// - prefetch window with upper halves decides forwarding
// - capability clear makes upper halves zero
// - prefetch limit field, low bits ones
module bsm_bridge_window (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [`BSM_ADDR_W-1:0] reg_addr,
    input wire bsm_pkg::bsm_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata_r,
    // Lock of the capability setting
    input wire logic cap_lock,
    // Secondary side events, one-cycle pulses
    input wire logic sec_err_msg,
    input wire logic sec_poisoned,
    // Forwarding request and decision
    input wire logic txn_valid,
    input wire bsm_pkg::bsm_txn_kind_t txn_kind,
    input wire bsm_pkg::bsm_addr_t txn_addr,
    output logic fwd_valid_r,
    output logic fwd_hit_r,
    // Interrupt
    output logic irq_r
);

    // ======================================================================
    // Helper functions
    // ======================================================================
    // Lowest byte of a window from its upper half and 1 MB field.
    function automatic bsm_pkg::bsm_addr_t win_lo(
        input logic [31:0] up,
        input bsm_pkg::bsm_field_t fld
    );
        win_lo = {up, fld, `BSM_GRAIN_ZERO};
    endfunction : win_lo

    // Highest byte of a window; the low 20 bits are implied ones.
    function automatic bsm_pkg::bsm_addr_t win_hi(
        input logic [31:0] up,
        input bsm_pkg::bsm_field_t fld
    );
        win_hi = {up, fld, `BSM_GRAIN_ONES};
    endfunction : win_hi

    // Replace the low or high half of a 32-bit upper register.
    function automatic logic [31:0] put_half(
        input logic [31:0] old,
        input bsm_pkg::bsm_word_t val,
        input logic upper
    );
        put_half = upper ? {val, old[15:0]} : {old[31:16], val};
    endfunction : put_half

    // ======================================================================
    // Register state
    // ======================================================================
    logic rx_sys_err_r;
    logic rx_sys_err_nxt;
    logic parity_err_r;
    logic parity_err_nxt;
    bsm_pkg::bsm_field_t mem_base_r;
    bsm_pkg::bsm_field_t mem_limit_r;
    bsm_pkg::bsm_field_t pf_base_r;
    bsm_pkg::bsm_field_t pf_limit_r;
    logic pf_cap_r;
    logic [31:0] pf_base_up_r;
    logic [31:0] pf_limit_up_r;
    logic serr_en_r;
    logic [`BSM_IRQ_W-1:0] irq_status_r;
    logic [`BSM_IRQ_W-1:0] irq_status_nxt;
    logic [`BSM_IRQ_W-1:0] irq_mask_r;
    logic [`BSM_IRQ_W-1:0] irq_mask_nxt;

    // ======================================================================
    // Write decode
    // ======================================================================
    // One strobe per register so each flop block stays a single line.
    wire wr_sec_status = reg_wr && (reg_addr == `BSM_OFF_SEC_STATUS);
    wire wr_mem_base = reg_wr && (reg_addr == `BSM_OFF_MEM_BASE);
    wire wr_mem_limit = reg_wr && (reg_addr == `BSM_OFF_MEM_LIMIT);
    wire wr_pf_base = reg_wr && (reg_addr == `BSM_OFF_PF_BASE);
    wire wr_pf_limit = reg_wr && (reg_addr == `BSM_OFF_PF_LIMIT);
    wire wr_bup_lo = reg_wr && (reg_addr == `BSM_OFF_PF_BASE_UP_LO);
    wire wr_bup_hi = reg_wr && (reg_addr == `BSM_OFF_PF_BASE_UP_HI);
    wire wr_lup_lo = reg_wr && (reg_addr == `BSM_OFF_PF_LIMIT_UP_LO);
    wire wr_lup_hi = reg_wr && (reg_addr == `BSM_OFF_PF_LIMIT_UP_HI);
    wire wr_bridge_control = reg_wr && (reg_addr == `BSM_OFF_BRIDGE_CTRL);
    wire wr_irq_status = reg_wr && (reg_addr == `BSM_OFF_IRQ_STATUS);
    wire wr_irq_mask = reg_wr && (reg_addr == `BSM_OFF_IRQ_MASK);

    // The upper halves only accept writes in 64-bit mode.
    wire up_writable = pf_cap_r;
    wire wr_pf_base_up = (wr_bup_lo || wr_bup_hi) && up_writable;
    wire wr_pf_limit_up = (wr_lup_lo || wr_lup_hi) && up_writable;
    wire wr_cap = wr_pf_base && !cap_lock;

    wire bsm_pkg::bsm_field_t wr_field =
        reg_wdata[`BSM_FLD_ADDR_HI:`BSM_FLD_ADDR_LO];

    // ======================================================================
    // Status flag next values
    // ======================================================================
    // The enable gates only the setting of the flag; a flag already set
    // stays until software clears it, even if the enable drops.
    wire set_rx_sys_err = sec_err_msg && serr_en_r;
    wire set_parity_err = sec_poisoned;
    wire clr_rx_sys_err = wr_sec_status && reg_wdata[`BSM_BIT_RX_SYS_ERR];
    wire clr_parity_err = wr_sec_status && reg_wdata[`BSM_BIT_PARITY_ERR];

    // A set arriving with a write-one-to-clear wins, so no event is lost.
    assign rx_sys_err_nxt = set_rx_sys_err ||
        (rx_sys_err_r && !clr_rx_sys_err);
    assign parity_err_nxt = set_parity_err ||
        (parity_err_r && !clr_parity_err);

    // Interrupt status mirrors the two events with its own clear.
    wire [`BSM_IRQ_W-1:0] irq_events = {set_parity_err, set_rx_sys_err};
    wire [`BSM_IRQ_W-1:0] irq_clear =
        wr_irq_status ? reg_wdata[`BSM_IRQ_W-1:0] : '0;
    assign irq_status_nxt = irq_events | (irq_status_r & ~irq_clear);

    // Mask next value, so a new mask reaches the line at its own write.
    assign irq_mask_nxt = wr_irq_mask ? reg_wdata[`BSM_IRQ_W-1:0] :
        irq_mask_r;

    // ======================================================================
    // Status flags and interrupt
    // ======================================================================
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_sys_err_r <= 1'b0;
            parity_err_r <= 1'b0;
            irq_status_r <= '0;
            irq_mask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            rx_sys_err_r <= rx_sys_err_nxt;
            parity_err_r <= parity_err_nxt;
            irq_status_r <= irq_status_nxt;
            irq_mask_r <= irq_mask_nxt;
            // Uses next status and mask so the line never lags a cycle.
            irq_r <= |(irq_status_nxt & irq_mask_nxt);
        end
    end

    // ======================================================================
    // Window registers and bridge control
    // ======================================================================
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mem_base_r <= `BSM_MEM_BASE_RST;
            mem_limit_r <= `BSM_MEM_LIMIT_RST;
            pf_base_r <= `BSM_PF_BASE_RST;
            pf_limit_r <= `BSM_PF_LIMIT_RST;
            pf_cap_r <= `BSM_PF_CAP_RST;
            serr_en_r <= 1'b0;
        end else begin
            if (wr_mem_base) begin
                mem_base_r <= wr_field;
            end
            if (wr_mem_limit) begin
                mem_limit_r <= wr_field;
            end
            if (wr_pf_base) begin
                pf_base_r <= wr_field;
            end
            if (wr_cap) begin
                pf_cap_r <= reg_wdata[`BSM_BIT_PF_CAP];
            end
            if (wr_pf_limit) begin
                pf_limit_r <= wr_field;
            end
            if (wr_bridge_control) begin
                serr_en_r <= reg_wdata[`BSM_BIT_SERR_EN];
            end
        end
    end

    // Upper halves of the prefetchable window, written 16 bits at a time.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pf_base_up_r <= `BSM_PF_BASE_UP_RST;
            pf_limit_up_r <= `BSM_PF_LIMIT_UP_RST;
        end else begin
            if (wr_pf_base_up) begin
                pf_base_up_r <= put_half(pf_base_up_r, reg_wdata, wr_bup_hi);
            end
            if (wr_pf_limit_up) begin
                pf_limit_up_r <= put_half(pf_limit_up_r, reg_wdata,
                    wr_lup_hi);
            end
        end
    end

    // ======================================================================
    // Read data
    // ======================================================================
    // In 32-bit mode the stored upper halves are kept but hidden, so that
    // switching back to 64-bit mode does not need them rewritten.
    wire [31:0] base_up_vis = pf_cap_r ? pf_base_up_r : 32'h00000000;
    wire [31:0] limit_up_vis = pf_cap_r ? pf_limit_up_r : 32'h00000000;

    // Bits 13:8 and 7:0 are never driven, so they read as zero.
    wire bsm_pkg::bsm_word_t sec_status_rd = {parity_err_r, rx_sys_err_r,
        14'h0000};
    wire bsm_pkg::bsm_word_t mem_base_rd = {mem_base_r, 4'h0};
    wire bsm_pkg::bsm_word_t mem_limit_rd = {mem_limit_r, 4'h0};
    wire bsm_pkg::bsm_word_t pf_base_rd = {pf_base_r, 3'h0,
        pf_cap_r};
    wire bsm_pkg::bsm_word_t pf_limit_rd = {pf_limit_r, 3'h0,
        pf_cap_r};
    wire bsm_pkg::bsm_word_t bridge_control_rd = {14'h0000, serr_en_r, 1'b0};
    wire bsm_pkg::bsm_word_t irq_status_rd = {14'h0000, irq_status_r};
    wire bsm_pkg::bsm_word_t irq_mask_rd = {14'h0000, irq_mask_r};

    bsm_pkg::bsm_word_t rd_mux;
    always_comb begin
        unique case (reg_addr)
            `BSM_OFF_SEC_STATUS: rd_mux = sec_status_rd;
            `BSM_OFF_MEM_BASE: rd_mux = mem_base_rd;
            `BSM_OFF_MEM_LIMIT: rd_mux = mem_limit_rd;
            `BSM_OFF_PF_BASE: rd_mux = pf_base_rd;
            `BSM_OFF_PF_LIMIT: rd_mux = pf_limit_rd;
            `BSM_OFF_PF_BASE_UP_LO: rd_mux = base_up_vis[15:0];
            `BSM_OFF_PF_BASE_UP_HI: rd_mux = base_up_vis[31:16];
            `BSM_OFF_PF_LIMIT_UP_LO: rd_mux = limit_up_vis[15:0];
            `BSM_OFF_PF_LIMIT_UP_HI: rd_mux = limit_up_vis[31:16];
            `BSM_OFF_BRIDGE_CTRL: rd_mux = bridge_control_rd;
            `BSM_OFF_IRQ_STATUS: rd_mux = irq_status_rd;
            `BSM_OFF_IRQ_MASK: rd_mux = irq_mask_rd;
            default: rd_mux = 16'h0000;
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata_r <= 16'h0000;
        end else begin
            reg_rdata_r <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // ======================================================================
    // Forwarding windows
    // ======================================================================
    bsm_win_if mem_win ();
    bsm_win_if pf_win ();

    // Non-prefetchable window lives below 4 GB.
    assign mem_win.lo = win_lo(32'h00000000, mem_base_r);
    assign mem_win.hi = win_hi(32'h00000000, mem_limit_r);
    assign mem_win.addr = txn_addr;

    // Prefetchable window; upper halves count as zero in 32-bit mode.
    assign pf_win.lo = win_lo(base_up_vis, pf_base_r);
    assign pf_win.hi = win_hi(limit_up_vis, pf_limit_r);
    assign pf_win.addr = txn_addr;

    bsm_win_cmp u_mem_cmp (
        .win(mem_win.cmp)
    );

    bsm_win_cmp u_pf_cmp (
        .win(pf_win.cmp)
    );

    wire sel_hit = (txn_kind == bsm_pkg::BSM_TXN_PREF) ?
        pf_win.hit : mem_win.hit;

    // Decision is registered: one cycle from request to answer.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fwd_valid_r <= 1'b0;
            fwd_hit_r <= 1'b0;
        end else begin
            fwd_valid_r <= txn_valid;
            fwd_hit_r <= txn_valid && sel_hit;
        end
    end

endmodule : bsm_bridge_window

`default_nettype wire

// file: tb/bsm_bridge_window_properties.sv
// Concurrent checks on the ports of the bridge window block.
`timescale 1ns/100ps
`default_nettype none
`include "bsm_cfg.svh"

module bsm_bridge_window_properties (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [`BSM_ADDR_W-1:0] reg_addr,
    input wire bsm_pkg::bsm_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata_r,
    // Events and forwarding
    input wire logic sec_err_msg,
    input wire logic sec_poisoned,
    input wire logic txn_valid,
    input wire logic fwd_valid_r,
    input wire logic fwd_hit_r
);
    // ======================================================================
    // Shadow flags
    // ======================================================================
    // Set beats a clear at the same edge, as the status flags must.
    logic serr_en_r;
    logic rse_r;
    logic dpe_r;
    wire logic wr_sts = reg_wr && reg_addr == 8'h1e;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            serr_en_r <= 1'b0;
            rse_r <= 1'b0;
            dpe_r <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == 8'h3e) begin
                serr_en_r <= reg_wdata[1];
            end
            rse_r <= (rse_r && !(wr_sts && reg_wdata[14]))
                || (sec_err_msg && serr_en_r);
            dpe_r <= (dpe_r && !(wr_sts && reg_wdata[15])) || sec_poisoned;
        end
    end

    // ======================================================================
    // Properties
    // ======================================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence rd_status;
        reg_rd && reg_addr == 8'h1e;
    endsequence
    sequence rd_window;
        reg_rd && (reg_addr == 8'h20 || reg_addr == 8'h22);
    endsequence
    a_rse_tracks_events:
        assert property (rd_status |=> reg_rdata_r[14] == $past(rse_r))
        else $error("system error flag wrong");
    a_dpe_tracks_events:
        assert property (rd_status |=> reg_rdata_r[15] == $past(dpe_r))
        else $error("parity flag wrong");
    a_status_low_zero:
        assert property (rd_status |=> reg_rdata_r[13:0] == 14'h0000)
        else $error("fixed status bits not zero");
    a_window_rsvd_zero:
        assert property (rd_window |=> reg_rdata_r[3:0] == 4'h0)
        else $error("window reserved bits not zero");
    a_pfbase_rsvd_zero:
        assert property (reg_rd && reg_addr == 8'h24 |=> !reg_rdata_r[3:1])
        else $error("prefetch base reserved bits set");
    a_rdata_idle_zero:
        assert property (!reg_rd |=> reg_rdata_r == 16'h0000)
        else $error("read data outside a read");
    a_fwd_answer_due:
        assert property (fwd_valid_r == $past(txn_valid))
        else $error("forwarding answer missing");
    a_hit_needs_valid:
        assert property (fwd_hit_r |-> fwd_valid_r && $past(txn_valid))
        else $error("hit without a query");
endmodule : bsm_bridge_window_properties

bind bsm_bridge_window bsm_bridge_window_properties
    u_bsm_bridge_window_properties (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .sec_err_msg(sec_err_msg), .sec_poisoned(sec_poisoned),
    .txn_valid(txn_valid), .fwd_valid_r(fwd_valid_r), .fwd_hit_r(fwd_hit_r)
);

`default_nettype wire

// file: tb/bsm_host_model.sv
// Host model issuing configuration reads and writes to the block.
`timescale 1ns/100ps
`default_nettype none
`include "bsm_cfg.svh"

module bsm_host_model (
    // Clock
    input wire logic clock,
    // Register port
    output logic [`BSM_ADDR_W-1:0] reg_addr,
    output bsm_pkg::bsm_word_t reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata_r
);
    // Bus is idle at time zero.
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Data is inverted after the strobe so a stale value never helps.
    task automatic wr(input logic [7:0] a, input bsm_pkg::bsm_word_t d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr

    // Read data is taken in the one cycle where it stands.
    task automatic rd(input logic [7:0] a, output bsm_pkg::bsm_word_t d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        d = reg_rdata_r;
    endtask : rd
endmodule : bsm_host_model

`default_nettype wire

// file: tb/bsm_bridge_window_tb_top.sv
// Self-checking bench for the bridge window block.
`timescale 1ns/100ps
`default_nettype none
`include "bsm_cfg.svh"

module bsm_bridge_window_tb_top;
    // ======================================================================
    // Signals and shadows
    // ======================================================================
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr;
    bsm_pkg::bsm_word_t reg_wdata;
    logic reg_wr, reg_rd, fwd_valid_r, fwd_hit_r, irq_r;
    logic [15:0] reg_rdata_r;
    logic cap_lock = 1'b0;
    logic sec_err_msg = 1'b0;
    logic sec_poisoned = 1'b0;
    logic txn_valid = 1'b0;
    bsm_pkg::bsm_txn_kind_t txn_kind = bsm_pkg::BSM_TXN_NONPREF;
    bsm_pkg::bsm_addr_t txn_addr = 64'h0;
    int err_total = 0;
    int n_checks = 0;
    logic [11:0] mb, ml, pb, pl;
    logic [31:0] pbu, plu;
    logic cap;
    logic [7:0] ra [13] = '{8'h1e, 8'h20, 8'h22, 8'h24, 8'h26, 8'h28,
        8'h2a, 8'h2c, 8'h2e, 8'h3e, 8'h80, 8'h82, 8'h40};
    logic [15:0] rv [13] = '{16'h0000, 16'hfff0, 16'h0000, 16'hfff1,
        16'h0001, 16'h000f, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000};

    // Clock inverts every half period of 5 ns.
    always #5 clock = ~clock;

    bsm_bridge_window u_bsm_bridge_window (
        .clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_r(reg_rdata_r), .cap_lock(cap_lock),
        .sec_err_msg(sec_err_msg), .sec_poisoned(sec_poisoned),
        .txn_valid(txn_valid), .txn_kind(txn_kind), .txn_addr(txn_addr),
        .fwd_valid_r(fwd_valid_r), .fwd_hit_r(fwd_hit_r), .irq_r(irq_r)
    );
    bsm_host_model u_bsm_host_model (
        .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r)
    );

    // ======================================================================
    // Helpers
    // ======================================================================
    // Expected hit: upper halves count only for prefetchable with cap set.
    function automatic logic exp_hit(input logic k, input logic [63:0] a);
        logic [63:0] lo;
        logic [63:0] hi;
        lo = {(k && cap) ? pbu : 32'h0, k ? pb : mb, 20'h00000};
        hi = {(k && cap) ? plu : 32'h0, k ? pl : ml, 20'hfffff};
        return lo <= hi && a >= lo && a <= hi;
    endfunction : exp_hit

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_bsm_host_model.wr(a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        bsm_pkg::bsm_word_t d;
        u_bsm_host_model.rd(a, d);
        check(d, exp);
    endtask : rdc

    task automatic pulse(input logic err, input logic poi);
        @(posedge clock);
        sec_err_msg <= err;
        sec_poisoned <= poi;
        @(posedge clock);
        sec_err_msg <= 1'b0;
        sec_poisoned <= 1'b0;
        @(negedge clock);
    endtask : pulse

    task automatic query(input logic k, input logic [63:0] a);
        @(posedge clock);
        txn_valid <= 1'b1;
        txn_kind <= bsm_pkg::bsm_txn_kind_t'(k);
        txn_addr <= a;
        @(posedge clock);
        txn_valid <= 1'b0;
        txn_addr <= ~a;
        @(negedge clock);
        check({fwd_valid_r, fwd_hit_r}, {1'b1, exp_hit(k, a)});
    endtask : query

    // Reserved bits are written high; uppers go in before cap may drop.
    task automatic program_windows();
        mb = 12'($urandom);
        ml = mb + 12'($urandom_range(0, 3)) - 12'h001;
        pb = 12'($urandom);
        pl = pb + 12'($urandom_range(0, 3)) - 12'h001;
        pbu = $urandom_range(0, 2);
        plu = pbu + $urandom_range(0, 1);
        cap = $urandom_range(0, 3) != 0;
        wr(8'h20, {mb, 4'hf});
        wr(8'h22, {ml, 4'hf});
        wr(8'h24, {pb, 4'hf});
        wr(8'h26, {pl, 4'hf});
        wr(8'h28, pbu[15:0]);
        wr(8'h2a, pbu[31:16]);
        wr(8'h2c, plu[15:0]);
        wr(8'h2e, plu[31:16]);
        if (!cap) begin
            wr(8'h24, {pb, 4'h0});
        end
    endtask : program_windows

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        logic k;
        logic [11:0] f;
        logic [63:0] a;
        void'($urandom(15388));
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        foreach (ra[i]) rdc(ra[i], rv[i]);
        wr(8'h1e, 16'hffff);
        rdc(8'h1e, 16'h0000);
        wr(8'h40, 16'hffff);
        rdc(8'h40, 16'h0000);
        // A locked capability keeps its value while the field moves.
        @(posedge clock);
        cap_lock <= 1'b1;
        wr(8'h24, 16'h1230);
        rdc(8'h24, 16'h1231);
        @(posedge clock);
        cap_lock <= 1'b0;
        wr(8'h24, 16'h1230);
        rdc(8'h26, 16'h0000);
        wr(8'h28, 16'h5a5a);
        rdc(8'h28, 16'h0000);
        // Error messages count only once the enable is set.
        wr(8'h82, 16'h0003);
        pulse(1'b1, 1'b0);
        check({15'h0, irq_r}, 16'h0000);
        rdc(8'h1e, 16'h0000);
        wr(8'h3e, 16'h0002);
        pulse(1'b1, 1'b0);
        check({15'h0, irq_r}, 16'h0001);
        pulse(1'b0, 1'b1);
        rdc(8'h1e, 16'hc000);
        rdc(8'h80, 16'h0003);
        wr(8'h1e, 16'h4000);
        rdc(8'h1e, 16'h8000);
        wr(8'h80, 16'h0003);
        wr(8'h82, 16'h0000);
        wr(8'h1e, 16'h8000);
        pulse(1'b0, 1'b1);
        check({15'h0, irq_r}, 16'h0000);
        rdc(8'h1e, 16'h8000);
        // Unmasking a pending event raises the line at the mask write.
        wr(8'h82, 16'h0002);
        @(negedge clock);
        check({15'h0, irq_r}, 16'h0001);
        // Random windows probed at and just beyond both edges.
        for (int i = 0; i < 40; i++) begin
            program_windows();
            for (int j = 0; j < 8; j++) begin
                k = 1'($urandom_range(0, 1));
                f = k ? (j[0] ? pl : pb) : (j[0] ? ml : mb);
                a = {k ? (j[1] ? plu : pbu) : 32'h0,
                    f + 12'($urandom_range(0, 2)) - 12'h001,
                    j[2] ? {20{j[0]}} : 20'($urandom)};
                query(k, a);
            end
        end
        print_verdict();
    end

    // Watchdog well beyond the fewer than two thousand cycles the run needs.
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        print_verdict();
    end
endmodule : bsm_bridge_window_tb_top

`default_nettype wire
